// File: mba_pkg.sv
// shared constants and types for the modulo and bit-reversed address generator
`default_nettype none
package mba_pkg;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned REG_AW   = 4;
  // register offsets on the plain register port
  localparam logic [3:0]  MBA_OFS_CIRC_CTRL  = 4'h0;
  localparam logic [3:0]  MBA_OFS_CIRC_START = 4'h1;
  localparam logic [3:0]  MBA_OFS_CIRC_END   = 4'h2;
  localparam logic [3:0]  MBA_OFS_REV_CTRL   = 4'h3;
  localparam logic [3:0]  MBA_OFS_STATUS     = 4'h4;
  localparam logic [3:0]  MBA_OFS_LAST_EA    = 4'h5;
  // circular_mode_control fields
  localparam int unsigned MBA_CIRC_EN_BIT    = 15;
  localparam int unsigned MBA_RPS_LSB        = 8;
  localparam int unsigned MBA_CPS_LSB        = 0;
  localparam int unsigned MBA_SEL_W          = 4;
  // reverse_addressing_control fields
  localparam int unsigned MBA_REV_EN_BIT     = 15;
  localparam int unsigned MBA_REV_MOD_MSB    = 14;
  // status fields
  localparam int unsigned MBA_ST_REV_BIT     = 0;
  localparam int unsigned MBA_ST_CIRC_BIT    = 1;
  localparam int unsigned MBA_ST_WB_BIT      = 2;
  // reset values
  localparam logic [15:0] MBA_CIRC_CTRL_RST  = 16'h0f0f;
  localparam logic [15:0] MBA_CIRC_START_RST = 16'h0000;
  localparam logic [15:0] MBA_CIRC_END_RST   = 16'h0000;
  localparam logic [15:0] MBA_REV_CTRL_RST   = 16'h0000;
  localparam logic [15:0] MBA_ZERO           = 16'h0000;
  // pointer select value that disables reverse-carry addressing (stack pointer)
  localparam logic [3:0]  MBA_NO_POINTER     = 4'hf;
  localparam logic [15:0] MBA_WORD_STEP      = 16'h0002;
  localparam logic [15:0] MBA_BYTE_STEP      = 16'h0001;
  localparam logic [15:0] MBA_EVEN_MASK      = 16'hfffe;

  typedef enum logic [5:0] {
    MBA_AM_DIRECT   = 6'b000001,
    MBA_AM_POST_INC = 6'b000010,
    MBA_AM_POST_DEC = 6'b000100,
    MBA_AM_PRE_INC  = 6'b001000,
    MBA_AM_PRE_DEC  = 6'b010000,
    MBA_AM_REG_OFS  = 6'b100000
  } mba_amode_e;

  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        byte_access;
    logic [3:0]  ptr_sel;
    mba_amode_e  mode;
    logic [15:0] ptr_val;
    logic [15:0] offset;
  } mba_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        wb_en;
    logic [3:0]  wb_sel;
    logic [15:0] wb_val;
    logic        rev_used;
    logic        circ_fixed;
  } mba_resp_s;
endpackage
`default_nettype wire

// File: mba_circ_fix.sv
// circular buffer boundary correction for one address generator path
`timescale 1ns/10ps
`default_nettype none
module mba_circ_fix
  import mba_pkg::*;
(
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] buf_start,
  input  wire logic [15:0] buf_end,
  input  wire logic        dir_up,
  input  wire logic        enable,
  output logic      [15:0] addr_out,
  output logic             corrected
);
  logic [15:0] buf_len;
  logic        over_top;
  logic        under_bottom;

  // length of the buffer in bytes, end address inclusive
  assign buf_len      = 16'(buf_end - buf_start + 16'h0001);
  // beyond the boundary, not only equal, so larger jumps wrap correctly
  assign over_top     = dir_up && (addr_in > buf_end);
  assign under_bottom = !dir_up && (addr_in < buf_start);

  // wrap back into the buffer by one buffer length
  always_comb
  begin
    addr_out  = addr_in;
    corrected = 1'b0;
    if (enable && over_top)
    begin
      addr_out  = 16'(addr_in - buf_len);
      corrected = 1'b1;
    end
    else if (enable && under_bottom)
    begin
      addr_out  = 16'(addr_in + buf_len);
      corrected = 1'b1;
    end
  end
endmodule // mba_circ_fix
`default_nettype wire

// File: mba_addr_gen.sv
// effective address generator with circular and reverse-carry addressing
//
// Notes on behaviour
// - circular correction available for any pointer register
// - up compares top, down bottom, overshoot
// - pointer written back only for pre/post modify
// - reverse-carry only on X writes
// - modifier bit-reversed, addresses kept normal order
// - enable needs select not 15, bit, increment
// - 15-bit modifier field is the pivot
// - word data, modifier scaled, address bit zero
// - otherwise normal addresses, bytes included
// - pointer plus modifier, mode increment ignored
// - reverse-carry beats circular on writes only
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module mba_addr_gen
(
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [15:0]          reg_rdata,
  input  wire mba_pkg::mba_req_s    req,
  output mba_pkg::mba_resp_s        resp
);
  import mba_pkg::*;

  // reset release path
  logic        rst_meta_r;
  logic        rst_sync_r;
  logic        rst_n;

  // software visible registers
  logic [15:0] circ_ctrl_r;
  logic [15:0] circ_start_r;
  logic [15:0] circ_end_r;
  logic [15:0] rev_ctrl_r;
  logic [15:0] status_r;
  logic [15:0] last_ea_r;
  logic [15:0] rdata_r;

  // decoded control fields
  logic        circ_en;
  logic [3:0]  circ_sel;
  logic [3:0]  rev_sel;
  logic        rev_en;
  logic [14:0] rev_mod;
  logic [15:0] rev_mod_bytes;

  // request decode
  logic        is_inc;
  logic        is_dec;
  logic        is_pre;
  logic        is_post;
  logic        is_modify;
  logic [15:0] step;
  logic [15:0] moved;
  logic        dir_up;
  logic        circ_hit;
  logic        rev_active;

  // per path results
  logic [15:0] rd_fixed;
  logic        rd_corr;
  logic [15:0] wr_fixed;
  logic        wr_corr;
  logic [15:0] ptr_even;
  logic [15:0] rev_sum;
  logic [15:0] new_ptr;
  logic        new_corr;
  logic [15:0] ea_nxt;

  // output register
  mba_resp_s   resp_r;

  // reset is taken asynchronously and released through two flip-flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // bit order swap used by the reverse-carry adder
  function automatic logic [15:0] flip16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // control register fields
  assign circ_en       = circ_ctrl_r[MBA_CIRC_EN_BIT];
  assign circ_sel      = circ_ctrl_r[MBA_CPS_LSB +: MBA_SEL_W];
  assign rev_sel       = circ_ctrl_r[MBA_RPS_LSB +: MBA_SEL_W];
  assign rev_en        = rev_ctrl_r[MBA_REV_EN_BIT];
  assign rev_mod       = rev_ctrl_r[MBA_REV_MOD_MSB:0];  // pivot, half the fft buffer
  // the pivot counts words, so it shifts up one place into bytes
  assign rev_mod_bytes = {rev_mod, 1'b0};

  // register writes; a write lands in the next cycle's address decisions
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      circ_ctrl_r  <= MBA_CIRC_CTRL_RST;
      circ_start_r <= MBA_CIRC_START_RST;
      circ_end_r   <= MBA_CIRC_END_RST;
      rev_ctrl_r   <= MBA_REV_CTRL_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        MBA_OFS_CIRC_CTRL:  circ_ctrl_r  <= reg_wdata;
        MBA_OFS_CIRC_START: circ_start_r <= reg_wdata;
        MBA_OFS_CIRC_END:   circ_end_r   <= reg_wdata;
        MBA_OFS_REV_CTRL:   rev_ctrl_r   <= reg_wdata;
        default:            circ_ctrl_r  <= circ_ctrl_r;  // read-only or unmapped
      endcase
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= MBA_ZERO;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        MBA_OFS_CIRC_CTRL:  rdata_r <= circ_ctrl_r;
        MBA_OFS_CIRC_START: rdata_r <= circ_start_r;
        MBA_OFS_CIRC_END:   rdata_r <= circ_end_r;
        MBA_OFS_REV_CTRL:   rdata_r <= rev_ctrl_r;
        MBA_OFS_STATUS:     rdata_r <= status_r;
        MBA_OFS_LAST_EA:    rdata_r <= last_ea_r;
        default:            rdata_r <= MBA_ZERO;
      endcase
    end
    else
    begin
      rdata_r <= MBA_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

  // addressing mode classes
  always_comb
  begin
    is_inc  = 1'b0;
    is_dec  = 1'b0;
    is_pre  = 1'b0;
    is_post = 1'b0;
    unique case (req.mode)
      MBA_AM_DIRECT:   is_post = 1'b0;
      MBA_AM_POST_INC:
      begin
        is_inc  = 1'b1;
        is_post = 1'b1;
      end
      MBA_AM_POST_DEC:
      begin
        is_dec  = 1'b1;
        is_post = 1'b1;
      end
      MBA_AM_PRE_INC:
      begin
        is_inc = 1'b1;
        is_pre = 1'b1;
      end
      MBA_AM_PRE_DEC:
      begin
        is_dec = 1'b1;
        is_pre = 1'b1;
      end
      MBA_AM_REG_OFS:  is_pre = 1'b0;
      default:         is_pre = 1'b0;  // an illegal mode code acts as plain indirect
    endcase
  end

  assign is_modify = is_pre || is_post;
  assign step      = req.byte_access ? MBA_BYTE_STEP : MBA_WORD_STEP;

  // candidate address before any boundary correction
  always_comb
  begin
    moved  = req.ptr_val;
    dir_up = 1'b1;
    if (is_inc)
    begin
      moved  = 16'(req.ptr_val + step);
      dir_up = 1'b1;
    end
    else if (is_dec)
    begin
      moved  = 16'(req.ptr_val - step);
      dir_up = 1'b0;
    end
    else if (req.mode == MBA_AM_REG_OFS)
    begin
      moved  = 16'(req.ptr_val + req.offset);
      dir_up = !req.offset[15];  // a negative offset walks the buffer down
    end
  end

  // circular correction applies to whichever pointer is chosen
  assign circ_hit = circ_en && (req.ptr_sel == circ_sel)
                    && (is_modify || (req.mode == MBA_AM_REG_OFS));

  // reverse-carry only for x writes of words with an increment mode
  assign rev_active = rev_en
                      && (rev_sel != MBA_NO_POINTER)
                      && (req.ptr_sel == rev_sel)
                      && (req.mode inside {MBA_AM_PRE_INC, MBA_AM_POST_INC})
                      && !req.byte_access
                      && req.is_write;

  // read generator keeps circular correction in every case
  mba_circ_fix u_rd_fix
  (
    .addr_in   (moved),
    .buf_start (circ_start_r),
    .buf_end   (circ_end_r),
    .dir_up    (dir_up),
    .enable    (circ_hit),
    .addr_out  (rd_fixed),
    .corrected (rd_corr)
  );

  // write generator loses circular correction while reverse-carry is active
  mba_circ_fix u_wr_fix
  (
    .addr_in   (moved),
    .buf_start (circ_start_r),
    .buf_end   (circ_end_r),
    .dir_up    (dir_up),
    .enable    (circ_hit && !rev_active),
    .addr_out  (wr_fixed),
    .corrected (wr_corr)
  );

  // pointer forced even; only word data is reordered
  assign ptr_even = req.ptr_val & MBA_EVEN_MASK;

  // adding the mirrored operands makes carries run from high to low bits;
  // the mode step is not part of this sum
  assign rev_sum = flip16(16'(flip16(ptr_even) + flip16(rev_mod_bytes)))
                   & MBA_EVEN_MASK;

  // choose the updated pointer of the generator that serves this access
  always_comb
  begin
    new_ptr  = rd_fixed;
    new_corr = rd_corr;
    if (req.is_write)
    begin
      if (rev_active)
      begin
        new_ptr  = rev_sum;
        new_corr = 1'b0;
      end
      else
      begin
        new_ptr  = wr_fixed;
        new_corr = wr_corr;
      end
    end
  end

  // post modes use the old pointer, pre and offset modes the new one
  always_comb
  begin
    ea_nxt = req.ptr_val;
    if (is_pre || (req.mode == MBA_AM_REG_OFS))
    begin
      ea_nxt = new_ptr;
    end
    else if (is_post && rev_active)
    begin
      ea_nxt = ptr_even;
    end
  end

  // result register towards the pipeline, one cycle after the request
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_r <= '0;
    end
    else
    begin
      resp_r.valid      <= req.valid;
      resp_r.ea         <= ea_nxt;
      // offset mode corrects the access but leaves the pointer alone
      resp_r.wb_en      <= req.valid && is_modify;
      resp_r.wb_sel     <= req.ptr_sel;
      resp_r.wb_val     <= new_ptr;
      resp_r.rev_used   <= req.valid && rev_active;
      resp_r.circ_fixed <= req.valid && new_corr;
    end
  end

  assign resp = resp_r;

  // status of the most recent access, for software to inspect
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_r  <= MBA_ZERO;
      last_ea_r <= MBA_ZERO;
    end
    else if (req.valid)
    begin
      status_r                  <= MBA_ZERO;
      status_r[MBA_ST_REV_BIT]  <= rev_active;
      status_r[MBA_ST_CIRC_BIT] <= new_corr;
      status_r[MBA_ST_WB_BIT]   <= is_modify;
      last_ea_r                 <= ea_nxt;
    end
  end
endmodule // mba_addr_gen
`default_nettype wire

// File: mba_addr_gen_chk.sv
// concurrent checks on the address generator ports
`timescale 1ns/10ps
`default_nettype none
module mba_addr_gen_chk
  import mba_pkg::*;
(
  input wire logic               clock,
  input wire logic               arst_n,
  input wire logic [3:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata,
  input wire mba_pkg::mba_req_s  req,
  input wire mba_pkg::mba_resp_s resp
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // answer timing: exactly one cycle, never unasked
  resp_timing_a: assert property (req.valid |=> resp.valid)
    else $error("response missing after request");
  resp_idle_a: assert property (!req.valid |=> !resp.valid)
    else $error("response without request");
  // modes that must leave the pointer alone
  direct_plain_a: assert property (req.valid && req.mode == MBA_AM_DIRECT
    |=> !resp.wb_en && resp.ea == $past(req.ptr_val)) else $error("direct mode altered");
  offset_keep_a: assert property (req.valid && req.mode == MBA_AM_REG_OFS
    |=> !resp.wb_en) else $error("offset mode wrote pointer");
  // reverse carry only where it is allowed
  rev_write_only_a: assert property (req.valid && !req.is_write
    |=> !resp.rev_used) else $error("reverse carry on read");
  rev_word_only_a: assert property (req.valid && (req.byte_access ||
    !(req.mode inside {MBA_AM_PRE_INC, MBA_AM_POST_INC})) |=> !resp.rev_used)
    else $error("reverse carry on wrong access");
  rev_no_stack_a: assert property (req.valid && req.ptr_sel == MBA_NO_POINTER
    |=> !resp.rev_used) else $error("reverse carry on stack pointer");
  rev_even_a: assert property (resp.rev_used |-> !resp.ea[0] && !resp.wb_val[0])
    else $error("odd reverse carry address");
  rev_over_circ_a: assert property (resp.rev_used |-> !resp.circ_fixed)
    else $error("circular fix under reverse carry");
  post_old_ea_a: assert property (req.valid && req.mode == MBA_AM_POST_INC &&
    !req.byte_access |=> resp.ea[15:1] == $past(req.ptr_val[15:1]))
    else $error("post mode address not old pointer");
endmodule // mba_addr_gen_chk
bind mba_addr_gen mba_addr_gen_chk i_chk (.clock, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .req, .resp);
`default_nettype wire

// File: mba_cpu_model.sv
// cpu pipeline model: pointer file, request issue, write-back
`timescale 1ns/10ps
`default_nettype none
module mba_cpu_model
  import mba_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic               load,
  input  wire mba_pkg::mba_req_s  cmd,
  input  wire mba_pkg::mba_resp_s resp,
  output var mba_pkg::mba_req_s   req
);
  logic [15:0] ptr_r [16];
  // forward a write-back not yet landed, as the real pipeline does
  always_comb
  begin
    req         = cmd;
    req.valid   = cmd.valid && !load;
    req.ptr_val = (resp.wb_en && resp.wb_sel == cmd.ptr_sel) ? resp.wb_val
                                                             : ptr_r[cmd.ptr_sel];
  end
  // pointer file; a preload wins over a write-back in the same cycle
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      ptr_r <= '{default: 16'h0000};
    else if (load)
      ptr_r[cmd.ptr_sel] <= cmd.ptr_val;
    else if (resp.wb_en)
      ptr_r[resp.wb_sel] <= resp.wb_val;
  end
endmodule // mba_cpu_model
`default_nettype wire

// File: mba_addr_gen_test.sv
// self-checking testbench for the address generator
`timescale 1ns/10ps
`default_nettype none
module mba_addr_gen_test;
  import mba_pkg::*;
  logic clock, arst_n, reg_wr, reg_rd, load, chk_nxt, chk_cur;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  mba_req_s    cmd, req;
  mba_resp_s   resp, exp_nxt, exp_cur;
  int          mismatches, checks, cyc;
  logic [15:0] rst_v [7] = '{MBA_CIRC_CTRL_RST, MBA_CIRC_START_RST, MBA_CIRC_END_RST,
                             MBA_REV_CTRL_RST, MBA_ZERO, MBA_ZERO, MBA_ZERO};
  mba_addr_gen i_dut (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .req, .resp);
  mba_cpu_model i_cpu (.clock, .arst_n, .load, .cmd, .resp, .req);
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic wrap_up;
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // register access: write, or read checked in the cycle after the strobe
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    cmd.valid <= 1'b0;
    chk_nxt   <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (!w)
    begin
      @(negedge clock);
      cmp({4'h0, reg_rdata}, {4'h0, d});
      // read data must fall back to zero one cycle later
      @(negedge clock);
      cmp({4'h0, reg_rdata}, 20'h00000);
    end
  endtask
  // preload one pointer of the model
  task automatic ld(input logic [3:0] s, input logic [15:0] v);
    @(posedge clock);
    cmd     <= '{1'b0, 1'b0, 1'b0, s, MBA_AM_DIRECT, v, 16'h0000};
    chk_nxt <= 1'b0;
    load    <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
  endtask
  // one request; calls follow each other with no gap
  task automatic op(input logic [3:0] s, input mba_amode_e m, input logic w, b,
                    input logic [15:0] o, ea, wv, input logic we, rv, cf);
    @(posedge clock);
    cmd     <= '{1'b1, w, b, s, m, 16'h0000, o};
    exp_nxt <= '{1'b1, ea, we, s, wv, rv, cf};
    chk_nxt <= 1'b1;
  endtask
  // expectation pipeline and hang guard
  always @(posedge clock)
  begin
    chk_cur <= chk_nxt;
    exp_cur <= exp_nxt;
    cyc     <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // response compared where it stands, mid-cycle
  always @(negedge clock)
  begin
    if (chk_cur)
    begin
      cmp({resp.valid, resp.ea, resp.wb_en, resp.rev_used, resp.circ_fixed},
          {1'b1, exp_cur.ea, exp_cur.wb_en, exp_cur.rev_used, exp_cur.circ_fixed});
      if (exp_cur.wb_en)
        cmp({resp.wb_sel, resp.wb_val}, {exp_cur.wb_sel, exp_cur.wb_val});
    end
  end
  initial
  begin
    {arst_n, reg_wr, reg_rd, load, chk_nxt, reg_addr, reg_wdata} = '0;
    cmd = '0;
    exp_nxt = '0;
    mismatches = 0;
    checks = 0;
    cyc = 0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 7; i++)
      acc(1'b0, 4'(i), rst_v[i]);
    acc(1'b1, MBA_OFS_STATUS, 16'hffff);
    acc(1'b0, MBA_OFS_STATUS, MBA_ZERO);
    acc(1'b1, MBA_OFS_CIRC_CTRL, 16'h8f01);
    acc(1'b1, MBA_OFS_CIRC_START, 16'h0100);
    acc(1'b1, MBA_OFS_CIRC_END, 16'h010f);
    ld(4'h1, 16'h010e);
    op(4'h1, MBA_AM_POST_INC, 1, 0, 0, 16'h010e, 16'h0100, 1, 0, 1);
    op(4'h1, MBA_AM_PRE_INC, 1, 0, 0, 16'h0102, 16'h0102, 1, 0, 0);
    op(4'h1, MBA_AM_PRE_DEC, 0, 0, 0, 16'h0100, 16'h0100, 1, 0, 0);
    op(4'h1, MBA_AM_PRE_DEC, 0, 0, 0, 16'h010e, 16'h010e, 1, 0, 1);
    op(4'h1, MBA_AM_REG_OFS, 0, 0, 4, 16'h0102, 16'h0000, 0, 0, 1);
    op(4'h1, MBA_AM_DIRECT, 0, 0, 0, 16'h010e, 16'h0000, 0, 0, 0);
    acc(1'b1, MBA_OFS_CIRC_CTRL, 16'h8f09);
    ld(4'h9, 16'h010f);
    op(4'h9, MBA_AM_POST_INC, 0, 1, 0, 16'h010f, 16'h0100, 1, 0, 1);
    acc(1'b1, MBA_OFS_CIRC_CTRL, 16'h0200);
    acc(1'b1, MBA_OFS_REV_CTRL, 16'h8004);
    acc(1'b0, MBA_OFS_REV_CTRL, 16'h8004);
    ld(4'h2, 16'h0200);
    op(4'h2, MBA_AM_POST_INC, 1, 0, 0, 16'h0200, 16'h0208, 1, 1, 0);
    op(4'h2, MBA_AM_POST_INC, 1, 0, 0, 16'h0208, 16'h0204, 1, 1, 0);
    op(4'h2, MBA_AM_POST_INC, 1, 0, 0, 16'h0204, 16'h020c, 1, 1, 0);
    op(4'h2, MBA_AM_PRE_INC, 1, 0, 0, 16'h0202, 16'h0202, 1, 1, 0);
    ld(4'h2, 16'h0201);
    op(4'h2, MBA_AM_POST_INC, 1, 0, 0, 16'h0200, 16'h0208, 1, 1, 0);
    op(4'h2, MBA_AM_POST_INC, 0, 0, 0, 16'h0208, 16'h020a, 1, 0, 0);
    op(4'h2, MBA_AM_POST_INC, 1, 1, 0, 16'h020a, 16'h020b, 1, 0, 0);
    op(4'h2, MBA_AM_POST_DEC, 1, 0, 0, 16'h020b, 16'h0209, 1, 0, 0);
    op(4'h3, MBA_AM_POST_INC, 1, 0, 0, 16'h0000, 16'h0002, 1, 0, 0);
    op(4'h2, MBA_AM_REG_OFS, 1, 0, 2, 16'h020b, 16'h0000, 0, 0, 0);
    acc(1'b1, MBA_OFS_REV_CTRL, 16'h0004);
    op(4'h2, MBA_AM_POST_INC, 1, 0, 0, 16'h0209, 16'h020b, 1, 0, 0);
    acc(1'b1, MBA_OFS_CIRC_CTRL, 16'h0f00);
    acc(1'b1, MBA_OFS_REV_CTRL, 16'h8004);
    ld(4'hf, 16'h0200);
    op(4'hf, MBA_AM_POST_INC, 1, 0, 0, 16'h0200, 16'h0202, 1, 0, 0);
    acc(1'b1, MBA_OFS_CIRC_CTRL, 16'h8202);
    acc(1'b1, MBA_OFS_CIRC_START, 16'h0200);
    acc(1'b1, MBA_OFS_CIRC_END, 16'h0203);
    ld(4'h2, 16'h0200);
    op(4'h2, MBA_AM_POST_INC, 1, 0, 0, 16'h0200, 16'h0208, 1, 1, 0);
    ld(4'h2, 16'h0202);
    op(4'h2, MBA_AM_POST_INC, 0, 0, 0, 16'h0202, 16'h0200, 1, 0, 1);
    acc(1'b0, MBA_OFS_STATUS, 16'h0006);
    acc(1'b0, MBA_OFS_LAST_EA, 16'h0202);
    op(4'h2, MBA_AM_REG_OFS, 0, 0, 16'hfffc, 16'h0200, 16'h0000, 0, 0, 1);
    acc(1'b0, MBA_OFS_LAST_EA, 16'h0200);
    wrap_up();
  end
endmodule // mba_addr_gen_test
`default_nettype wire
